//--- core/ao_pkg.sv
// Contract
// - Output code is 12-bit unsigned, scaled linearly
// - Range switch: off 1-5V/4-20mA, on 0-10V
// - Wide range applies to both channels together
// - Config words load only at reset or restart
// - Limiting holds output between lower and upper
// - Out-of-limit request sets limit flag, bits 05-08
// - Alarm only reports, never alters output
// - Upper alarm: set at >=, clear below minus deadband
// - Lower alarm: set at <=, clear above plus deadband
// - Any alarm lights indicator and alarm terminals
// - Pulse switch adds pulse output on one channel
// - Channel switch picks pulsed channel, never both
// - Duty resolution is 1/256 of period
// - Control bits 02:00 select period 1-20 s
// - Duty comes from channel data, 0FFF full
// - New duty or period waits for period end
// - Status bit 00 flags invalid loaded config
// - Alarm flags in status bits 01 to 04
package ao_pkg;

  // ==========================================================
  // Register map (word index on the plain register port)
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 16;
  localparam int          CODE_W        = 12;
  localparam logic [3:0]  REG_OUT1      = 4'h0;
  localparam logic [3:0]  REG_OUT2      = 4'h1;
  localparam logic [3:0]  REG_CTRL      = 4'h2;
  localparam logic [3:0]  REG_STATUS    = 4'h3;
  localparam logic [3:0]  REG_CFG_LOLIM = 4'h4;
  localparam logic [3:0]  REG_CFG_HILIM = 4'h5;
  localparam logic [3:0]  REG_CFG_ALMLO = 4'h6;
  localparam logic [3:0]  REG_CFG_ALMHI = 4'h7;
  localparam logic [3:0]  REG_CFG_DEAD  = 4'h8;
  localparam logic [3:0]  REG_RESTART   = 4'h9;

  // ==========================================================
  // Control word fields
  localparam int CTRL_W          = 9;
  localparam int CTRL_PERIOD_LSB = 0;
  localparam int CTRL_ALM1       = 4;
  localparam int CTRL_ALM2       = 5;
  localparam int CTRL_LIM1       = 6;
  localparam int CTRL_LIM2       = 7;
  localparam int CTRL_PROHIBIT   = 8;

  // ==========================================================
  // Status word fields
  localparam int STAT_CFG_ERR = 0;
  localparam int STAT_ALM1_LO = 1;
  localparam int STAT_ALM1_HI = 2;
  localparam int STAT_ALM2_LO = 3;
  localparam int STAT_ALM2_HI = 4;
  localparam int STAT_LIM1_LO = 5;
  localparam int STAT_LIM1_HI = 6;
  localparam int STAT_LIM2_LO = 7;
  localparam int STAT_LIM2_HI = 8;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [11:0] RST_CODE = 12'h000;
  localparam logic [11:0] CODE_MAX = 12'hfff;

  // ==========================================================
  // Pulse timing: one phase step is 1/256 of a 1 s period
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint STEP_TIME_PS  = 64'd1_000_000_000_000 / 256;
  localparam int     STEP_CYCLES   = int'(STEP_TIME_PS / CLK_PERIOD_PS);
  localparam int     STEP_W        = 20;
  localparam logic [2:0] PER_1S  = 3'h0;
  localparam logic [2:0] PER_2S  = 3'h1;
  localparam logic [2:0] PER_5S  = 3'h2;
  localparam logic [2:0] PER_10S = 3'h3;
  localparam logic [2:0] PER_20S = 3'h4;
  localparam logic [4:0] MULT_1S  = 5'h01;
  localparam logic [4:0] MULT_2S  = 5'h02;
  localparam logic [4:0] MULT_5S  = 5'h05;
  localparam logic [4:0] MULT_10S = 5'h0a;
  localparam logic [4:0] MULT_20S = 5'h14;
  localparam logic [8:0] DUTY_FULL = 9'h100;

endpackage : ao_pkg

//--- core/pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  output logic      level
);

  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } sync_s;

  sync_s s_reg;
  sync_s s_next;

  // First stage feeds only the second; the last two must agree
  always_comb begin
    s_next       = s_reg;
    s_next.stage = {s_reg.stage[1:0], pinIn};
    if (s_reg.stage[1] == s_reg.stage[2]) begin
      s_next.level = s_reg.stage[2];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;

endmodule : pin_sync

//--- core/chan_limit_alarm.sv
`timescale 1ns/10ps
module chan_limit_alarm (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [11:0] request,
  input  wire logic        limitEn,
  input  wire logic        alarmEn,
  input  wire logic [11:0] loLim,
  input  wire logic [11:0] hiLim,
  input  wire logic [11:0] almLo,
  input  wire logic [11:0] almHi,
  input  wire logic [11:0] dead,
  output logic [11:0]      code,
  output logic             limLoFlag,
  output logic             limHiFlag,
  output logic             almLoFlag,
  output logic             almHiFlag
);

  typedef struct packed {
    logic [11:0] code;
    logic        limLo;
    logic        limHi;
    logic        almLo;
    logic        almHi;
  } chan_s;

  chan_s c_reg;
  chan_s c_next;

  always_comb begin
    c_next = c_reg;
    c_next.code  = request;
    c_next.limLo = 1'b0;
    c_next.limHi = 1'b0;
    if (limitEn) begin
      if (request > hiLim) begin
        c_next.code  = hiLim;
        c_next.limHi = 1'b1;
      end else if (request < loLim) begin
        c_next.code  = loLim;
        c_next.limLo = 1'b1;
      end
    end
    // Alarms watch the driven code and never feed back into it
    if (!alarmEn) begin
      c_next.almHi = 1'b0;
      c_next.almLo = 1'b0;
    end else begin
      if (c_reg.code >= almHi) begin
        c_next.almHi = 1'b1;
      end else if (({1'b0, c_reg.code} + {1'b0, dead}) < {1'b0, almHi}) begin
        c_next.almHi = 1'b0;
      end
      if (c_reg.code <= almLo) begin
        c_next.almLo = 1'b1;
      end else if ({1'b0, c_reg.code} > ({1'b0, almLo} + {1'b0, dead})) begin
        c_next.almLo = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign code      = c_reg.code;
  assign limLoFlag = c_reg.limLo;
  assign limHiFlag = c_reg.limHi;
  assign almLoFlag = c_reg.almLo;
  assign almHiFlag = c_reg.almHi;

endmodule : chan_limit_alarm

//--- core/analog_out_core.sv
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
module analog_out_core #(
  parameter logic [19:0] STEP_CYCLES = 20'(ao_pkg::STEP_CYCLES)
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdata,
  input  wire logic        rangeSwitch,
  input  wire logic        pulseEnSwitch,
  input  wire logic        pulseChSwitch,
  output logic [11:0]      dacCode1,
  output logic [11:0]      dacCode2,
  output logic             rangeWide1,
  output logic             rangeWide2,
  output logic             pulseOut1,
  output logic             pulseOut2,
  output logic             alarmLed,
  output logic [3:0]       alarmTerm
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [11:0] outData1;
    logic [11:0] outData2;
    logic [8:0]  ctrl;
    logic [15:0] stLoLim;
    logic [15:0] stHiLim;
    logic [15:0] stAlmLo;
    logic [15:0] stAlmHi;
    logic [15:0] stDead;
    logic [11:0] loLim;
    logic [11:0] hiLim;
    logic [11:0] almLo;
    logic [11:0] almHi;
    logic [11:0] dead;
    logic        cfgErr;
    logic        loadPend;
    logic [15:0] rdata;
    logic [11:0] dac1;
    logic [11:0] dac2;
    logic        rangeWide;
    logic [19:0] stepCnt;
    logic [4:0]  multCnt;
    logic [4:0]  mult;
    logic [7:0]  phase;
    logic [8:0]  duty;
    logic        pulseCh;
    logic        pulseOn;
    logic        pulseEn;
  } core_s;

  core_s s_reg;
  core_s s_next;

  // ==========================================================
  // Switch inputs
  logic rangeLevel;
  logic pulseEnLevel;
  logic pulseChLevel;

  pin_sync u_syncRange (
    .mclk   (mclk),
    .arst_n (arst_n),
    .pinIn  (rangeSwitch),
    .level  (rangeLevel)
  );

  pin_sync u_syncPulseEn (
    .mclk   (mclk),
    .arst_n (arst_n),
    .pinIn  (pulseEnSwitch),
    .level  (pulseEnLevel)
  );

  pin_sync u_syncPulseCh (
    .mclk   (mclk),
    .arst_n (arst_n),
    .pinIn  (pulseChSwitch),
    .level  (pulseChLevel)
  );

  // ==========================================================
  // Channels
  logic [11:0] chanCode1;
  logic [11:0] chanCode2;
  logic        limLo1;
  logic        limHi1;
  logic        almLo1;
  logic        almHi1;
  logic        limLo2;
  logic        limHi2;
  logic        almLo2;
  logic        almHi2;

  chan_limit_alarm u_chan1 (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .request   (s_reg.outData1),
    .limitEn   (s_reg.ctrl[ao_pkg::CTRL_LIM1]),
    .alarmEn   (s_reg.ctrl[ao_pkg::CTRL_ALM1]),
    .loLim     (s_reg.loLim),
    .hiLim     (s_reg.hiLim),
    .almLo     (s_reg.almLo),
    .almHi     (s_reg.almHi),
    .dead      (s_reg.dead),
    .code      (chanCode1),
    .limLoFlag (limLo1),
    .limHiFlag (limHi1),
    .almLoFlag (almLo1),
    .almHiFlag (almHi1)
  );

  chan_limit_alarm u_chan2 (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .request   (s_reg.outData2),
    .limitEn   (s_reg.ctrl[ao_pkg::CTRL_LIM2]),
    .alarmEn   (s_reg.ctrl[ao_pkg::CTRL_ALM2]),
    .loLim     (s_reg.loLim),
    .hiLim     (s_reg.hiLim),
    .almLo     (s_reg.almLo),
    .almHi     (s_reg.almHi),
    .dead      (s_reg.dead),
    .code      (chanCode2),
    .limLoFlag (limLo2),
    .limHiFlag (limHi2),
    .almLoFlag (almLo2),
    .almHiFlag (almHi2)
  );

  // ==========================================================
  // Status word
  logic [15:0] statusWord;

  always_comb begin
    statusWord = ao_pkg::RST_WORD;
    statusWord[ao_pkg::STAT_CFG_ERR] = s_reg.cfgErr;
    statusWord[ao_pkg::STAT_ALM1_LO] = almLo1;
    statusWord[ao_pkg::STAT_ALM1_HI] = almHi1;
    statusWord[ao_pkg::STAT_ALM2_LO] = almLo2;
    statusWord[ao_pkg::STAT_ALM2_HI] = almHi2;
    statusWord[ao_pkg::STAT_LIM1_LO] = limLo1;
    statusWord[ao_pkg::STAT_LIM1_HI] = limHi1;
    statusWord[ao_pkg::STAT_LIM2_LO] = limLo2;
    statusWord[ao_pkg::STAT_LIM2_HI] = limHi2;
  end

  // ==========================================================
  // Config validation
  logic cfgBad;

  // Limits must fit 12 bits and be ordered; a bad set is not taken
  assign cfgBad = (|s_reg.stLoLim[15:12]) || (|s_reg.stHiLim[15:12])
               || (|s_reg.stAlmLo[15:12]) || (|s_reg.stAlmHi[15:12])
               || (|s_reg.stDead[15:12])
               || (s_reg.stLoLim > s_reg.stHiLim)
               || (s_reg.stAlmLo > s_reg.stAlmHi);

  // ==========================================================
  // Pulse period decode
  logic [4:0] multSel;

  always_comb begin
    case (s_reg.ctrl[ao_pkg::CTRL_PERIOD_LSB +: 3])
      ao_pkg::PER_1S:  multSel = ao_pkg::MULT_1S;
      ao_pkg::PER_2S:  multSel = ao_pkg::MULT_2S;
      ao_pkg::PER_5S:  multSel = ao_pkg::MULT_5S;
      ao_pkg::PER_10S: multSel = ao_pkg::MULT_10S;
      ao_pkg::PER_20S: multSel = ao_pkg::MULT_20S;
      default:         multSel = ao_pkg::MULT_1S;
    endcase
  end

  logic [11:0] dutySrc;
  logic [8:0]  dutySel;

  assign dutySrc = pulseChLevel ? s_reg.outData2 : s_reg.outData1;
  // Top code must reach a steady high level despite the 8-bit step
  assign dutySel = (dutySrc == ao_pkg::CODE_MAX) ? ao_pkg::DUTY_FULL
                                                 : {1'b0, dutySrc[11:4]};

  // ==========================================================
  // Next state
  always_comb begin
    s_next          = s_reg;
    s_next.rdata    = ao_pkg::RST_WORD;
    // Cleared first so a restart written during a load is not lost
    s_next.loadPend = 1'b0;

    if (regWr) begin
      case (regAddr)
        ao_pkg::REG_OUT1:      s_next.outData1 = regWdata[11:0];
        ao_pkg::REG_OUT2:      s_next.outData2 = regWdata[11:0];
        ao_pkg::REG_CTRL:      s_next.ctrl     = regWdata[8:0];
        ao_pkg::REG_CFG_LOLIM: s_next.stLoLim  = regWdata;
        ao_pkg::REG_CFG_HILIM: s_next.stHiLim  = regWdata;
        ao_pkg::REG_CFG_ALMLO: s_next.stAlmLo  = regWdata;
        ao_pkg::REG_CFG_ALMHI: s_next.stAlmHi  = regWdata;
        ao_pkg::REG_CFG_DEAD:  s_next.stDead   = regWdata;
        ao_pkg::REG_RESTART: begin
          if (regWdata[0]) begin
            s_next.loadPend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (regRd) begin
      case (regAddr)
        ao_pkg::REG_OUT1:      s_next.rdata = {4'h0, s_reg.outData1};
        ao_pkg::REG_OUT2:      s_next.rdata = {4'h0, s_reg.outData2};
        ao_pkg::REG_CTRL:      s_next.rdata = {7'h00, s_reg.ctrl};
        ao_pkg::REG_STATUS:    s_next.rdata = statusWord;
        ao_pkg::REG_CFG_LOLIM: s_next.rdata = s_reg.stLoLim;
        ao_pkg::REG_CFG_HILIM: s_next.rdata = s_reg.stHiLim;
        ao_pkg::REG_CFG_ALMLO: s_next.rdata = s_reg.stAlmLo;
        ao_pkg::REG_CFG_ALMHI: s_next.rdata = s_reg.stAlmHi;
        ao_pkg::REG_CFG_DEAD:  s_next.rdata = s_reg.stDead;
        default:               s_next.rdata = ao_pkg::RST_WORD;
      endcase
    end

    // Staged words only reach the limit logic here, never on write
    if (s_reg.loadPend) begin
      s_next.cfgErr   = cfgBad;
      if (!cfgBad) begin
        s_next.loLim = s_reg.stLoLim[11:0];
        s_next.hiLim = s_reg.stHiLim[11:0];
        s_next.almLo = s_reg.stAlmLo[11:0];
        s_next.almHi = s_reg.stAlmHi[11:0];
        s_next.dead  = s_reg.stDead[11:0];
      end
    end

    // Alarms are not consulted here: codes come from limiting, or are zero while the prohibit bit is set
    if (s_reg.ctrl[ao_pkg::CTRL_PROHIBIT]) begin
      s_next.dac1 = ao_pkg::RST_CODE;
      s_next.dac2 = ao_pkg::RST_CODE;
    end else begin
      s_next.dac1 = chanCode1;
      s_next.dac2 = chanCode2;
    end
    s_next.rangeWide = rangeLevel;

    // Phase steps of 1/256 s, each repeated mult times per phase
    s_next.pulseEn = pulseEnLevel;
    if (s_reg.stepCnt >= STEP_CYCLES - 20'h0_0001) begin
      s_next.stepCnt = 20'h0_0000;
      if (s_reg.multCnt >= s_reg.mult - 5'h01) begin
        s_next.multCnt = 5'h00;
        s_next.phase   = s_reg.phase + 8'h01;
        if (s_reg.phase == 8'hff) begin
          s_next.mult    = multSel;
          s_next.duty    = dutySel;
          s_next.pulseCh = pulseChLevel;
        end
      end else begin
        s_next.multCnt = s_reg.multCnt + 5'h01;
      end
    end else begin
      s_next.stepCnt = s_reg.stepCnt + 20'h0_0001;
    end
    s_next.pulseOn = ({1'b0, s_next.phase} < s_next.duty);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg          <= '0;
      // Power-up counts as a load request
      s_reg.loadPend <= 1'b1;
      s_reg.mult     <= ao_pkg::MULT_1S;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign regRdata   = s_reg.rdata;
  assign dacCode1   = s_reg.dac1;
  assign dacCode2   = s_reg.dac2;
  assign rangeWide1 = s_reg.rangeWide;
  assign rangeWide2 = s_reg.rangeWide;
  // One select bit feeds both gates, so both can never pulse
  assign pulseOut1  = s_reg.pulseEn && !s_reg.pulseCh && s_reg.pulseOn;
  assign pulseOut2  = s_reg.pulseEn && s_reg.pulseCh && s_reg.pulseOn;
  assign alarmTerm  = {almHi2, almLo2, almHi1, almLo1};
  assign alarmLed   = |alarmTerm;

endmodule : analog_out_core

//--- bench/analog_out_core_properties.sv
`timescale 1ns/10ps
module analog_out_core_properties #(
  parameter logic [19:0] STEP_CYCLES = 20'h0_0004
) (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [3:0]  regAddr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire logic        rangeSwitch,
  input wire logic        pulseEnSwitch,
  input wire logic        rangeWide1,
  input wire logic        rangeWide2,
  input wire logic        pulseOut1,
  input wire logic        pulseOut2,
  input wire logic        alarmLed,
  input wire logic [3:0]  alarmTerm
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Pins and outputs
  pulse_excl_a: assert property (!(pulseOut1 && pulseOut2))
    else $error("both pulse outputs high");
  alarm_led_a: assert property (alarmLed == |alarmTerm)
    else $error("alarm indicator differs from alarm flags");
  range_same_a: assert property (rangeWide1 == rangeWide2)
    else $error("channels on different ranges");
  range_on_a: assert property (rangeSwitch [*8] |-> rangeWide1)
    else $error("wide range not selected");
  range_off_a: assert property (!rangeSwitch [*8] |-> !rangeWide1)
    else $error("wide range selected with switch off");
  pulse_idle_a: assert property (!pulseEnSwitch [*8] |-> !(pulseOut1 || pulseOut2))
    else $error("pulse output without pulse mode");
  // Sync latency is ignored by waiting until the switch has settled
  pulse_step_a: assert property ($rose(pulseOut1) && $past(pulseEnSwitch, 8) |=> pulseOut1)
    else $error("pulse shorter than one duty step");

  // ==========================================================
  // Register port
  status_alarm_a: assert property (regRd && regAddr == ao_pkg::REG_STATUS |=>
    (regRdata[4:1] == alarmTerm || regRdata[4:1] == $past(alarmTerm)))
    else $error("status alarm bits differ from terminals");
  read_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule : analog_out_core_properties

bind analog_out_core analog_out_core_properties #(.STEP_CYCLES(STEP_CYCLES)) i_props (
  .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
  .rangeSwitch(rangeSwitch), .pulseEnSwitch(pulseEnSwitch), .rangeWide1(rangeWide1),
  .rangeWide2(rangeWide2), .pulseOut1(pulseOut1), .pulseOut2(pulseOut2),
  .alarmLed(alarmLed), .alarmTerm(alarmTerm)
);

//--- bench/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic mclk,
  output logic [3:0]  regAddr,
  output logic [15:0] regWdata,
  output logic        regWr,
  output logic        regRd
);
  initial begin
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // ==========================================================
  // Bus cycles; released lines show the inverse of the last value
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    regAddr <= ~a;
  endtask : rd

  // Config words only take hold through the restart
  task automatic cfg(input logic [15:0] lo, hi, al, ah, db);
    wr(ao_pkg::REG_CFG_LOLIM, lo);
    wr(ao_pkg::REG_CFG_HILIM, hi);
    wr(ao_pkg::REG_CFG_ALMLO, al);
    wr(ao_pkg::REG_CFG_ALMHI, ah);
    wr(ao_pkg::REG_CFG_DEAD, db);
    wr(ao_pkg::REG_RESTART, 16'h0001);
  endtask : cfg
endmodule : host_model

//--- bench/analog_out_limit_alarm_pulse_tb.sv
`timescale 1ns/10ps
module analog_out_limit_alarm_pulse_tb;
  localparam int STEP = 2;
  localparam int MULT [5] = '{1, 2, 5, 10, 20};
  localparam logic [11:0] EDGE [4] = '{12'h0ff, 12'h100, 12'hf00, 12'hf01};
  // {upper, lower, ch2 value}
  localparam logic [13:0] ALM [8] = '{14'h0300, 14'h0dff, 14'h2e00, 14'h2d81,
                                       14'h0d7f, 14'h1200, 14'h1280, 14'h0281};
  logic        mclk, arst_n, regWr, regRd, rdPend;
  logic [3:0]  regAddr, alarmTerm;
  logic [15:0] regWdata, regRdata;
  logic        rangeSwitch, pulseEnSwitch, pulseChSwitch;
  logic [11:0] dacCode1, dacCode2;
  logic        rangeWide1, rangeWide2, pulseOut1, pulseOut2, alarmLed;
  logic [15:0] expQ [$];
  int          badCount, nCompared, cyc, seed;

  analog_out_core #(.STEP_CYCLES(20'(STEP))) i_analog_out_core (
    .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .rangeSwitch(rangeSwitch),
    .pulseEnSwitch(pulseEnSwitch), .pulseChSwitch(pulseChSwitch), .dacCode1(dacCode1),
    .dacCode2(dacCode2), .rangeWide1(rangeWide1), .rangeWide2(rangeWide2),
    .pulseOut1(pulseOut1), .pulseOut2(pulseOut2), .alarmLed(alarmLed), .alarmTerm(alarmTerm)
  );
  host_model i_host_model (
    .mclk(mclk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd)
  );

  // ==========================================================
  // Checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic completeRun();
    if (badCount == 0 && nCompared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : completeRun

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    expQ.push_back(exp);
    i_host_model.rd(a);
  endtask : rd

  task automatic settle();
    repeat (8) @(negedge mclk);
  endtask : settle

  task automatic waitLvl(input bit ch, input bit lvl, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((ch ? pulseOut2 : pulseOut1) !== lvl && n < 30000);
    if (n >= 30000) check(32'h0, 32'h1);
  endtask : waitLvl

  always @(posedge mclk) rdPend <= regRd;
  always @(negedge mclk) begin
    if (rdPend === 1'b1) check(32'(regRdata), 32'(expQ.pop_front()));
  end

  // Whole run is about 32k cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      badCount++;
      $display("BAD %0t run too long", $time);
      completeRun();
    end
  end

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // Scenarios
  initial begin
    logic [11:0] v;
    logic [11:0] exp;
    int          n, h, l, miss;
    seed = 32656;
    cyc = 0;
    badCount = 0;
    nCompared = 0;
    arst_n = 1'b0;
    rangeSwitch = 1'b0;
    pulseEnSwitch = 1'b0;
    pulseChSwitch = 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    i_host_model.wr(ao_pkg::REG_CTRL, 16'h0060);
    i_host_model.cfg(16'h0100, 16'h0f00, 16'h0200, 16'h0e00, 16'h0080);
    for (int i = 0; i < 12; i++) begin
      v = (i < 4) ? EDGE[i] : 12'($random(seed));
      exp = (v < 12'h100) ? 12'h100 : (v > 12'hf00) ? 12'hf00 : v;
      i_host_model.wr(ao_pkg::REG_OUT1, {4'h0, v});
      settle();
      check(32'(dacCode1), 32'(exp));
      rd(ao_pkg::REG_STATUS, {9'h000, v > 12'hf00, v < 12'h100, 5'h08});
    end
    foreach (ALM[i]) begin
      i_host_model.wr(ao_pkg::REG_OUT2, {4'h0, ALM[i][11:0]});
      settle();
      check(32'(alarmTerm[3:2]), 32'(ALM[i][13:12]));
      check(32'(dacCode2), 32'(ALM[i][11:0]));
    end
    i_host_model.wr(ao_pkg::REG_OUT1, 16'h0fff);
    i_host_model.wr(ao_pkg::REG_CFG_HILIM, 16'h0800);
    settle();
    check(32'(dacCode1), 32'h0000_0f00);
    i_host_model.wr(ao_pkg::REG_RESTART, 16'h0001);
    settle();
    check(32'(dacCode1), 32'h0000_0800);
    i_host_model.cfg(16'h0900, 16'h0800, 16'h0200, 16'h0e00, 16'h0080);
    settle();
    check(32'(dacCode1), 32'h0000_0800);
    rd(ao_pkg::REG_STATUS, 16'h0041);
    rd(4'hf, 16'h0000);
    @(posedge mclk) rangeSwitch <= 1'b1;
    repeat (12) @(negedge mclk);
    check(32'({rangeWide1, rangeWide2}), 32'h0000_0003);
    @(posedge mclk) rangeSwitch <= 1'b0;
    // Pulse mode, 1 s period left from the control word
    @(posedge mclk) pulseEnSwitch <= 1'b1;
    repeat (1100) @(negedge mclk);
    miss = 0;
    repeat (600) begin
      @(negedge mclk);
      if (pulseOut1 !== 1'b1) miss++;
    end
    check(32'(miss), 32'h0000_0000);
    i_host_model.wr(ao_pkg::REG_OUT2, 16'h0800);
    @(posedge mclk) pulseChSwitch <= 1'b1;
    waitLvl(1'b1, 1'b1, n);
    check(32'({pulseOut1, pulseOut2}), 32'h0000_0001);
    i_host_model.wr(ao_pkg::REG_OUT1, 16'h0800);
    @(posedge mclk) pulseChSwitch <= 1'b0;
    foreach (MULT[c]) begin
      i_host_model.wr(ao_pkg::REG_CTRL, 16'(c));
      repeat (4) @(negedge mclk);
      waitLvl(1'b0, 1'b0, n);
      waitLvl(1'b0, 1'b1, n);
      waitLvl(1'b0, 1'b0, h);
      waitLvl(1'b0, 1'b1, l);
      check(32'(h), 32'(128 * STEP * MULT[c]));
      check(32'(h + l), 32'(256 * STEP * MULT[c]));
    end
    @(posedge mclk) pulseEnSwitch <= 1'b0;
    settle();
    check(32'({pulseOut1, pulseOut2}), 32'h0000_0000);
    i_host_model.wr(ao_pkg::REG_CTRL, 16'h0100);
    settle();
    check(32'({dacCode1, dacCode2}), 32'h0000_0000);
    completeRun();
  end
endmodule : analog_out_limit_alarm_pulse_tb
